// ### core/ssu_pkg.sv
// Package for the clocked serial channel: register map, fields, resets.
// Assumes a byte-wide register port and one 10 MHz system clock.
package ssu_pkg;
    // ************************************************************
    // Register indices
    // ************************************************************
    localparam logic [2:0] ADDR_BAUD_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_RECEIVE_DATA = 3'h1;
    localparam logic [2:0] ADDR_RECEIVE_STATUS_CONTROL = 3'h2;
    localparam logic [2:0] ADDR_BAUD_DIVISOR_LOW = 3'h3;
    localparam logic [2:0] ADDR_BAUD_DIVISOR_HIGH = 3'h4;
    localparam logic [2:0] ADDR_TRANSMIT_DATA = 3'h5;
    localparam logic [2:0] ADDR_TRANSMIT_STATUS_CONTROL = 3'h6;
    localparam logic [2:0] ADDR_INTERRUPT_CONTROL = 3'h7;
    // ************************************************************
    // Field positions
    // ************************************************************
    // Receive status/control
    localparam int RX_SERIAL_PORT_ENABLE = 7;
    localparam int RX_NINE = 6;
    localparam int RX_SINGLE_RECEIVE_ENABLE = 5;
    localparam int RX_CONTINUOUS_RECEIVE_ENABLE = 4;
    localparam int RX_FRAMING_ERROR_FLAG = 2;
    localparam int RX_OVERRUN_ERROR_FLAG = 1;
    localparam int RX_NINTH = 0;
    // Transmit status/control
    localparam int TX_CLOCK_SOURCE_SELECT = 7;
    localparam int TX_NINE = 6;
    localparam int TX_TRANSMIT_ENABLE = 5;
    localparam int TX_SYNC = 4;
    localparam int TX_HIGH_SPEED_BAUD_SELECT = 2;
    localparam int TX_TRMT = 1;
    localparam int TX_NINTH = 0;
    // Baud control
    localparam int BC_IDLE = 6;
    localparam int BC_WIDE = 3;
    // Interrupt control
    localparam int IC_GIE = 7;
    localparam int IC_PERIPHERAL_INTERRUPT_ENABLE = 6;
    localparam int IC_RCIE = 5;
    localparam int IC_TXIE = 4;
    localparam int IC_RCIF = 1;
    localparam int IC_TXIF = 0;
    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_COUNT = 4'h0;
    localparam logic [1:0] RST_FILL = 2'h0;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ssu_bus_t;

    typedef struct packed {
        logic wake;
        logic irq;
    } ssu_event_t;
endpackage

// ### core/ssu_channel.sv
// One synchronous serial channel: master receive and full slave mode.
// Assumes register strobes on ref_clk and serial pins from outside.
`timescale 1ns/100ps
// How it works
// - Clocked mode, port enable and clock source make a clock master.
// - Single or continuous receive enable starts master reception.
// - Completed character sets receive flag; enable raises interrupt.
// - Overrun clears with continuous enable or port enable; port resets all.
// - Clocked mode, clock source zero, port enable selects slave.
// - Slave transmits with continuous receive enable clear, else receives.
// - Two writes: first goes to shifter, second held, flag clear.
// - After first shifts out, second moves in and flag sets on the same clock.
// - Peripheral and transmit enables let transmit flag wake device.
// - Writing low byte to holding register starts slave transmit.
// - Slave receiver reads idle between characters and takes each clocked character until an overrun is flagged.
// - Single receive enable is ignored in slave mode.
// - Slave character during sleep still reaches receive data.
// - Receive interrupt wakes device; global enable decides vector.
// - Single receive makes exactly one character of clocks then clears.
// - Receiver samples data on the trailing clock edge.
// - Transmitter changes data on leading edge, one bit per clock.
// - Two-deep receive FIFO flags overrun, keeps data, stops taking.
module ssu_channel (
    input wire logic ref_clk,
    input wire logic srst,
    input wire ssu_pkg::ssu_bus_t bus,
    output logic [7:0] rdata,
    input wire logic data_in,
    output logic data_out,
    output logic data_oe,
    input wire logic clk_in,
    output logic clk_out,
    output logic clk_oe,
    output ssu_pkg::ssu_event_t events
);
    import ssu_pkg::*;

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] rcsta;
    logic [7:0] txsta;
    logic [7:0] bcon;
    logic [7:0] div_lo;
    logic [7:0] div_hi;
    logic [7:0] intcon;
    logic [8:0] hold;
    logic hold_full;
    logic [8:0] transmit_shifter;
    logic [3:0] tx_cnt;
    logic tx_busy;
    logic txif;
    logic [8:0] receive_shifter;
    logic [3:0] rx_cnt;
    logic [8:0] fifo [0:1];
    logic [1:0] fill;
    logic overrun_error_flag;
    logic [15:0] brg_cnt;
    logic ck_lvl;
    logic dt_s1, dt_s2, ck_s1, ck_s2, ck_s3;

    // ************************************************************
    // Decode
    // ************************************************************
    wire serial_port_enable = rcsta[RX_SERIAL_PORT_ENABLE];
    wire continuous_receive_enable = rcsta[RX_CONTINUOUS_RECEIVE_ENABLE];
    wire single_receive_enable = rcsta[RX_SINGLE_RECEIVE_ENABLE];
    wire sync = txsta[TX_SYNC];
    wire master = sync & serial_port_enable & txsta[TX_CLOCK_SOURCE_SELECT];
    wire slave = sync & serial_port_enable & ~txsta[TX_CLOCK_SOURCE_SELECT];
    wire rx_mode = continuous_receive_enable | (master & single_receive_enable);
    wire slave_rx = slave & rx_mode;
    wire slave_tx = slave & ~rx_mode & txsta[TX_TRANSMIT_ENABLE];
    wire nine_rx = rcsta[RX_NINE];
    wire nine_tx = txsta[TX_NINE];
    wire [3:0] rx_bits = nine_rx ? 4'h9 : 4'h8;
    wire [3:0] tx_bits = nine_tx ? 4'h9 : 4'h8;
    wire wr_rc = bus.wr & (bus.addr == ADDR_RECEIVE_STATUS_CONTROL);
    wire wr_tx = bus.wr & (bus.addr == ADDR_TRANSMIT_DATA);
    wire rd_rx = bus.rd & (bus.addr == ADDR_RECEIVE_DATA);
    wire [15:0] divisor = bcon[BC_WIDE] ? {div_hi, div_lo}
        : {8'h00, div_lo};
    wire brg_tick = (brg_cnt == 16'h0000);
    // Master clock runs while a receive is requested and no overrun is flagged
    wire m_run = master & rx_mode & ~overrun_error_flag;
    wire m_lead = m_run & brg_tick & ~ck_lvl;
    wire m_trail = m_run & brg_tick & ck_lvl;
    // Slave edges come only from the synchronised pin
    wire s_lead = slave & ck_s2 & ~ck_s3;
    wire s_trail = slave & ~ck_s2 & ck_s3;
    wire rx_edge = (m_trail | (slave_rx & s_trail)) & ~overrun_error_flag;
    wire [8:0] rx_next = nine_rx ? {dt_s2, receive_shifter[8:1]}
        : {1'b0, dt_s2, receive_shifter[7:1]};
    wire rx_done = rx_edge & (rx_cnt == rx_bits - 4'h1);
    wire tx_lead = slave_tx & s_lead;
    wire tx_last = tx_busy & slave_tx & s_trail & (tx_cnt == tx_bits);
    wire load_tsr = (~tx_busy | tx_last) & hold_full & slave_tx;
    wire pop = rd_rx & (fill != 2'h0);
    wire [8:0] top = fifo[0];
    wire rcif = (fill != 2'h0);
    wire [7:0] rd_rc = {rcsta[7:3], 1'b0, overrun_error_flag, top[8]};
    wire [7:0] rd_txs = {txsta[7:2], ~tx_busy, txsta[0]};
    wire [7:0] rd_ic = {intcon[7:4], 2'h0, rcif, txif};
    wire [7:0] rd_bc = {bcon[7], ~rx_cnt[0] & (rx_cnt == 4'h0),
        bcon[5:0]};
    wire [7:0] next_rdata =
        (bus.addr == ADDR_BAUD_CONTROL) ? rd_bc :
        (bus.addr == ADDR_RECEIVE_DATA) ? top[7:0] :
        (bus.addr == ADDR_RECEIVE_STATUS_CONTROL) ? rd_rc :
        (bus.addr == ADDR_BAUD_DIVISOR_LOW) ? div_lo :
        (bus.addr == ADDR_BAUD_DIVISOR_HIGH) ? div_hi :
        (bus.addr == ADDR_TRANSMIT_STATUS_CONTROL) ? rd_txs :
        (bus.addr == ADDR_INTERRUPT_CONTROL) ? rd_ic : RST_BYTE;
    wire rx_irq = rcif & intcon[IC_RCIE];
    wire tx_irq = txif & intcon[IC_TXIE];
    wire next_wake = intcon[IC_PERIPHERAL_INTERRUPT_ENABLE] & (rx_irq | tx_irq);
    wire next_irq = next_wake & intcon[IC_GIE];

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        dt_s1 <= data_in;
        dt_s2 <= dt_s1;
        ck_s1 <= clk_in;
        ck_s2 <= ck_s1;
        ck_s3 <= ck_s2;
    end

    // ************************************************************
    // Register writes and receive control
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rcsta <= RST_BYTE;
            txsta <= RST_BYTE;
            bcon <= RST_BYTE;
            div_lo <= RST_BYTE;
            div_hi <= RST_BYTE;
            intcon <= RST_BYTE;
        end else begin
            if (wr_rc) begin
                rcsta <= {bus.wdata[7:3], 3'h0};
            end else if (master & rx_done & single_receive_enable) begin
                rcsta[RX_SINGLE_RECEIVE_ENABLE] <= 1'b0;
            end
            if (bus.wr & (bus.addr == ADDR_TRANSMIT_STATUS_CONTROL)) begin
                txsta <= {bus.wdata[7:2], 1'b0, bus.wdata[0]};
            end
            if (bus.wr & (bus.addr == ADDR_BAUD_CONTROL)) begin
                bcon <= {1'b0, 1'b0, bus.wdata[5:0]};
            end
            if (bus.wr & (bus.addr == ADDR_BAUD_DIVISOR_LOW)) begin
                div_lo <= bus.wdata;
            end
            if (bus.wr & (bus.addr == ADDR_BAUD_DIVISOR_HIGH)) begin
                div_hi <= bus.wdata;
            end
            if (bus.wr & (bus.addr == ADDR_INTERRUPT_CONTROL)) begin
                intcon <= {bus.wdata[7:4], 4'h0};
            end
        end
    end

    // ************************************************************
    // Master clock generator
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (srst | ~m_run) begin
            brg_cnt <= divisor;
            ck_lvl <= 1'b0;
        end else if (brg_tick) begin
            brg_cnt <= divisor;
            ck_lvl <= ~ck_lvl;
        end else begin
            brg_cnt <= brg_cnt - 16'h0001;
        end
    end

    // ************************************************************
    // Receiver and FIFO
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (srst | ~serial_port_enable) begin
            receive_shifter <= 9'h000;
            rx_cnt <= RST_COUNT;
            fill <= RST_FILL;
            overrun_error_flag <= 1'b0;
            fifo[0] <= 9'h000;
            fifo[1] <= 9'h000;
        end else begin
            if (~rx_mode) begin
                rx_cnt <= RST_COUNT;
            end else if (rx_edge) begin
                receive_shifter <= rx_next;
                rx_cnt <= rx_done ? RST_COUNT : rx_cnt + 4'h1;
            end
            if (wr_rc & ~bus.wdata[RX_CONTINUOUS_RECEIVE_ENABLE]) begin
                overrun_error_flag <= 1'b0;
            end else if (pop & ~continuous_receive_enable) begin
                overrun_error_flag <= 1'b0;
            end else if (rx_done & (fill == 2'h2) & ~pop) begin
                overrun_error_flag <= 1'b1;
            end
            if (pop) begin
                fifo[0] <= fifo[1];
            end
            if (rx_done & ~(fill == 2'h2 & ~pop)) begin
                if (fill == 2'h0 | (fill == 2'h1 & pop)) begin
                    fifo[0] <= rx_next;
                end else begin
                    fifo[1] <= rx_next;
                end
                fill <= pop ? fill : fill + 2'h1;
            end else if (pop) begin
                fill <= fill - 2'h1;
            end
        end
    end

    // ************************************************************
    // Transmitter
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (srst | ~serial_port_enable) begin
            hold <= 9'h000;
            hold_full <= 1'b0;
            transmit_shifter <= 9'h000;
            tx_cnt <= RST_COUNT;
            tx_busy <= 1'b0;
            txif <= 1'b0;
            data_out <= 1'b0;
        end else begin
            if (wr_tx) begin
                hold <= {txsta[TX_NINTH], bus.wdata};
                hold_full <= 1'b1;
                txif <= 1'b0;
            end else if (load_tsr) begin
                hold_full <= 1'b0;
                txif <= 1'b1;
            end
            if (load_tsr) begin
                transmit_shifter <= hold;
                tx_cnt <= RST_COUNT;
                tx_busy <= 1'b1;
            end else if (tx_last) begin
                tx_busy <= 1'b0;
            end else if (tx_busy & tx_lead) begin
                data_out <= transmit_shifter[0];
                transmit_shifter <= {1'b0, transmit_shifter[8:1]};
                tx_cnt <= tx_cnt + 4'h1;
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rdata <= RST_BYTE;
            clk_out <= 1'b0;
            clk_oe <= 1'b0;
            data_oe <= 1'b0;
            events <= '0;
        end else begin
            rdata <= next_rdata;
            clk_out <= ck_lvl;
            clk_oe <= master;
            data_oe <= slave_tx & tx_busy;
            events <= '{wake: next_wake, irq: next_irq};
        end
    end
endmodule

// ### tb/ssu_channel_chk.sv
// Checker for the serial channel, watching only its ports.
// Assumes the register port is the only way to configure it.
`timescale 1ns/100ps
module ssu_channel_chk (
    input wire logic ref_clk,
    input wire logic srst,
    input wire ssu_pkg::ssu_bus_t bus,
    input wire logic [7:0] rdata,
    input wire logic data_in,
    input wire logic data_out,
    input wire logic data_oe,
    input wire logic clk_in,
    input wire logic clk_out,
    input wire logic clk_oe,
    input wire ssu_pkg::ssu_event_t events
);
    import ssu_pkg::*;
    // ************************************************************
    // Shadow of written configuration
    // ************************************************************
    logic sync, clock_source_select, serial_port_enable, rx_en, continuous_receive_enable, nine, peripheral_interrupt_enable, global_interrupt_enable, clk_q;
    logic [3:0] edges;
    wire wr_tx = bus.wr && bus.addr == ADDR_TRANSMIT_STATUS_CONTROL;
    wire wr_rc = bus.wr && bus.addr == ADDR_RECEIVE_STATUS_CONTROL;
    wire wr_ic = bus.wr && bus.addr == ADDR_INTERRUPT_CONTROL;
    wire master = sync && clock_source_select && serial_port_enable;
    wire slave = sync && !clock_source_select && serial_port_enable;
    wire stx = slave && !rx_en;
    wire rise = clk_out && !clk_q;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            {sync, clock_source_select, serial_port_enable, rx_en, continuous_receive_enable, nine, peripheral_interrupt_enable, global_interrupt_enable, clk_q} <= '0;
            edges <= 4'h0;
        end else begin
            clk_q <= clk_out;
            if (wr_tx) begin
                clock_source_select <= bus.wdata[TX_CLOCK_SOURCE_SELECT];
                sync <= bus.wdata[TX_SYNC];
            end
            if (wr_rc) begin
                serial_port_enable <= bus.wdata[RX_SERIAL_PORT_ENABLE];
                nine <= bus.wdata[RX_NINE];
                continuous_receive_enable <= bus.wdata[RX_CONTINUOUS_RECEIVE_ENABLE];
                rx_en <= bus.wdata[RX_CONTINUOUS_RECEIVE_ENABLE] || bus.wdata[RX_SINGLE_RECEIVE_ENABLE];
            end
            if (wr_ic) {global_interrupt_enable, peripheral_interrupt_enable} <= {bus.wdata[IC_GIE], bus.wdata[IC_PERIPHERAL_INTERRUPT_ENABLE]};
            if (wr_rc) edges <= 4'h0;
            else if (rise && edges != 4'hf) edges <= edges + 4'h1;
        end
    end
    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence port_off;
        wr_rc && !bus.wdata[RX_SERIAL_PORT_ENABLE];
    endsequence
    sequence lines_quiet;
        !clk_oe && !data_oe;
    endsequence
    irq_needs_wake_a: assert property (events.irq |->
        events.wake && (global_interrupt_enable || $past(global_interrupt_enable))) else $error("irq without cause");
    wake_needs_peripheral_interrupt_enable_a: assert property (events.wake |->
        peripheral_interrupt_enable || $past(peripheral_interrupt_enable) || $past(peripheral_interrupt_enable, 2)) else $error("stray wake");
    master_clock_a: assert property (master && $past(master) &&
        $past(master, 2) |-> clk_oe) else $error("master clock not driven");
    slave_no_clock_a: assert property (slave && $past(slave) &&
        $past(slave, 2) |-> !clk_oe) else $error("slave drives clock");
    slave_clk_still_a: assert property ($changed(clk_out) |->
        master || $past(master) || $past(master, 2)) else $error("clock moved");
    tx_only_slave_a: assert property (data_oe |->
        stx || $past(stx) || $past(stx, 2)) else $error("data driven");
    single_count_a: assert property (!continuous_receive_enable |->
        edges <= (nine ? 4'h9 : 4'h8)) else $error("too many clocks");
    serial_port_enable_off_a: assert property (port_off |-> ##[1:3] lines_quiet)
        else $error("port stays active");
endmodule
bind ssu_channel ssu_channel_chk u_chk (.ref_clk(ref_clk), .srst(srst),
    .bus(bus), .rdata(rdata), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .clk_in(clk_in), .clk_out(clk_out),
    .clk_oe(clk_oe), .events(events));

// ### tb/ssu_peer.sv
// Model of the far-side serial peer: clocks the slave, answers the master.
// Assumes the bench resolves the shared data and clock lines.
`timescale 1ns/100ps
module ssu_peer (
    output logic peer_clk,
    output logic peer_data,
    input wire logic clk_out,
    input wire logic line
);
    initial begin
        peer_clk = 1'b0;
        peer_data = 1'b0;
    end
    // Clocks one byte into a slave, LSB first, clock idle low
    task automatic clock_byte(input logic [7:0] tx, output logic [7:0] rx);
        #37;
        for (int i = 0; i < 8; i++) begin
            peer_data = tx[i];
            peer_clk = 1'b1;
            #400;
            peer_clk = 1'b0;
            #350;
            rx[i] = line;
            #50;
        end
        peer_data = ~tx[7];
    endtask
    // Answers a clock master, changing data on its leading edge
    task automatic answer(input logic [7:0] tx);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_out);
            peer_data = tx[i];
            @(negedge clk_out);
        end
        #400;
        peer_data = ~tx[7];
    endtask
endmodule

// ### tb/ssu_channel_tb.sv
// Self-checking bench for the serial channel with a peer model.
// Assumes the checker is bound to the channel by its own file.
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    fail_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module ssu_channel_tb;
    import ssu_pkg::*;
    logic ref_clk, srst, data_in, clk_in, data_out, data_oe;
    logic clk_out, clk_oe, peer_clk, peer_data;
    logic [7:0] rdata, got;
    ssu_bus_t bus;
    ssu_event_t events;
    int fail_count, comparisons;
    ssu_channel DUT (.ref_clk(ref_clk), .srst(srst), .bus(bus),
        .rdata(rdata), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .clk_in(clk_in), .clk_out(clk_out),
        .clk_oe(clk_oe), .events(events));
    ssu_peer peer (.peer_clk(peer_clk), .peer_data(peer_data),
        .clk_out(clk_out), .line(data_in));
    assign data_in = data_oe ? data_out : peer_data;
    assign clk_in = clk_oe ? clk_out : peer_clk;
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // ************************************************************
    // Bus tasks
    // ************************************************************
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk) bus <= {a, d, 2'b10};
        @(posedge ref_clk) bus <= {a, d, 2'b00};
    endtask
    task automatic chk_reg(string n, logic [2:0] a, logic [7:0] e);
        @(posedge ref_clk) bus <= {a, 8'h00, 2'b01};
        @(posedge ref_clk) bus <= {a, 8'h00, 2'b00};
        #1 `CHK(n, e, rdata)
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_master_rx;
        wr(ADDR_BAUD_DIVISOR_LOW, 8'h03);
        wr(ADDR_BAUD_CONTROL, 8'h00);
        chk_reg("divisor", ADDR_BAUD_DIVISOR_LOW, 8'h03);
        wr(ADDR_TRANSMIT_STATUS_CONTROL, 8'h90);
        wr(ADDR_RECEIVE_STATUS_CONTROL, 8'h80);
        wr(ADDR_INTERRUPT_CONTROL, 8'h60);
        wr(ADDR_RECEIVE_STATUS_CONTROL, 8'ha0);
        peer.answer(8'ha5);
        wait_cyc(10);
        `CHK("wake", 1'b1, events.wake)
        `CHK("irq", 1'b0, events.irq)
        chk_reg("rx flag", ADDR_INTERRUPT_CONTROL, 8'h62);
        chk_reg("status", ADDR_RECEIVE_STATUS_CONTROL, 8'h80);
        chk_reg("rx data", ADDR_RECEIVE_DATA, 8'ha5);
        wait_cyc(3);
        `CHK("wake off", 1'b0, events.wake)
    endtask
    task automatic t_slave_tx;
        wr(ADDR_RECEIVE_STATUS_CONTROL, 8'h00);
        wr(ADDR_TRANSMIT_STATUS_CONTROL, 8'h30);
        wr(ADDR_RECEIVE_STATUS_CONTROL, 8'h80);
        wr(ADDR_INTERRUPT_CONTROL, 8'h50);
        wr(ADDR_TRANSMIT_DATA, 8'h3c);
        wr(ADDR_TRANSMIT_DATA, 8'hc3);
        chk_reg("tx flag held", ADDR_INTERRUPT_CONTROL, 8'h50);
        peer.clock_byte(8'h00, got);
        `CHK("tx first", 8'h3c, got)
        wait_cyc(8);
        chk_reg("tx flag", ADDR_INTERRUPT_CONTROL, 8'h51);
        `CHK("tx wake", 1'b1, events.wake)
        peer.clock_byte(8'h00, got);
        `CHK("tx second", 8'hc3, got)
    endtask
    task automatic t_slave_rx;
        wr(ADDR_TRANSMIT_STATUS_CONTROL, 8'h10);
        wr(ADDR_INTERRUPT_CONTROL, 8'he0);
        wr(ADDR_RECEIVE_STATUS_CONTROL, 8'hb0);
        peer.clock_byte(8'h11, got);
        peer.clock_byte(8'h22, got);
        peer.clock_byte(8'h33, got);
        wait_cyc(8);
        `CHK("rx irq", 1'b1, events.irq)
        chk_reg("overrun", ADDR_RECEIVE_STATUS_CONTROL, 8'hb2);
        chk_reg("fifo 1", ADDR_RECEIVE_DATA, 8'h11);
        chk_reg("fifo 2", ADDR_RECEIVE_DATA, 8'h22);
        wr(ADDR_RECEIVE_STATUS_CONTROL, 8'ha0);
        chk_reg("ovr clear", ADDR_RECEIVE_STATUS_CONTROL, 8'ha0);
        `CHK("irq off", 1'b0, events.irq)
        wr(ADDR_RECEIVE_STATUS_CONTROL, 8'hb0);
        peer.clock_byte(8'h44, got);
        wait_cyc(8);
        chk_reg("rx again", ADDR_RECEIVE_DATA, 8'h44);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        srst = 1'b1;
        bus = '0;
        fail_count = 0;
        comparisons = 0;
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        t_master_rx;
        t_slave_tx;
        t_slave_rx;
        close_out;
    end
    initial begin
        #3000000;
        fail_count++;
        close_out;
    end
endmodule
